/* File: hw/cgs_clock_gen.sv */
// Clock generation and standby control with an APB register file.
// How it works
// - Main oscillator stop forces slow oscillator source and floats motor timer pins; PWM timer pins float on the newer variant only.
// - PLL input divider codes give 1, 2, then 4 or 3; 11 refused.
// - Older multiplier codes 000111 to 010011 give x4 to x10.
// - Newer multiplier codes 010011 to 111011 give x10 to x30.
// - Newer PLL input picks main or fast internal oscillator by bit 4.
// - Stop irq enable gates both the interrupt and the pin disable report.
// - Older wait code 0 gives 2 cycles, 1 to 7 give 1024 to 65536.
// - Drive field maps resonator ranges, two bits newer, one bit older.
// - Fast oscillator is 16, 18 or 20 MHz newer, fixed 32 MHz older.
// - Newer stable flags also report whether the watchdog oscillator is stable.
// - Newer: stop emits a link event; a link event selects slow oscillator.
// - System, peripheral A to D and flash clocks have their own dividers; older parts have no peripheral C divider.
// - A set module stop bit gates that module's clock.
// - Wait instruction enters the low power mode; interrupt or reset leaves.
// - Standby stops oscillators, PLL, CPU, memories and peripherals.
// - Sleep stops only the CPU; newer variant also holds the watchdog.
// - Standby select bit chooses sleep when 0 and standby when 1.
`timescale 1ns/100ps
`default_nettype none
module cgs_clock_gen #(
	parameter bit NEWER = 1'b1,
	parameter int MODULES = 32
) (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Oscillator observation: one-cycle ticks per main and slow oscillator edge, and stable and lock levels
	input  wire logic                main_osc_tick,
	input  wire logic                slow_osc_tick,
	input  wire logic                fast_osc_stable,
	input  wire logic                pll_locked,
	input  wire logic                wdog_osc_stable,
	// CPU and event link
	input  wire logic                wait_exec,
	input  wire logic                irq_pending,
	input  wire logic                link_to_slow,
	// Oscillator and divider controls
	output logic                     main_osc_en,
	output logic                     fast_osc_en,
	output logic                     slow_osc_en,
	output logic                     pll_en,
	output logic                     pll_from_fast,
	output logic [2:0]               pll_input_div,
	output logic [5:0]               pll_mult_halves,
	output logic [1:0]               main_osc_drive_range,
	output logic [5:0]               fast_osc_mhz,
	output logic [2:0]               clock_source,
	output logic [3:0]               system_clock_div,
	output logic [3:0]               periph_clock_a_div,
	output logic [3:0]               periph_clock_b_div,
	output logic [3:0]               periph_clock_c_div,
	output logic [3:0]               periph_clock_d_div,
	output logic [3:0]               flash_if_clock_div,
	// Gating and low power
	output logic                     cpu_clock_en,
	output logic                     memory_clock_en,
	output logic [MODULES-1:0]       module_clock_en,
	output logic                     wdt_hold,
	output logic                     cpu_wake,
	// Stop detection consequences
	output logic                     motor_timer_hiz,
	output logic                     pwm_timer_hiz,
	output logic                     stop_detect_irq,
	output logic                     stop_event_out
);
	cgs_osc_if osc ();

	logic [31:0]        sck;
	logic [15:0]        pllc;
	logic [7:0]         ostd;
	logic [7:0]         mwait;
	logic [7:0]         mdrv;
	logic [31:0]        oscc;
	logic               sby_sel;
	logic [MODULES-1:0] mstop;
	logic               stop_flag;
	logic               stop_prev;
	cgs_pkg::cgs_lp_t   lp;
	logic               wr;
	logic               rd;
	logic               mapped;
	logic               stop_rise;
	logic               force_slow;
	logic [7:0]         flags;
	logic [31:0]        rdata;

	cgs_osc_monitor #(
		.NEWER(NEWER)
	) u_mon (
		.pclk   (pclk),
		.presetn(presetn),
		.osc    (osc)
	);

	// The pulse inputs come from the oscillator sampling logic, already
	// in the bus clock domain.
	assign osc.main_tick = main_osc_tick;
	assign osc.slow_tick = slow_osc_tick;
	assign osc.main_en   = ~oscc[cgs_pkg::OSC_MAIN_STOP_POS]
		& (lp != cgs_pkg::CGS_STANDBY);
	assign osc.detect_en = ostd[cgs_pkg::OSTD_EN_POS];
	assign osc.wait_code = mwait;

	function automatic logic div_ok(input logic [1:0] code);
		div_ok = code != 2'h3;
	endfunction : div_ok

	function automatic logic mul_ok(input logic [5:0] code);
		if (NEWER)
			mul_ok = code >= 6'h13 && code <= 6'h3b;
		else
			mul_ok = code >= 6'h07 && code <= 6'h13;
	endfunction : mul_ok

	function automatic logic wait_ok(input logic [7:0] code);
		wait_ok = NEWER || code <= 8'h07;
	endfunction : wait_ok

	function automatic logic freq_ok(input logic [1:0] code);
		freq_ok = code != 2'h3;
	endfunction : freq_ok

	assign wr = psel & penable & pwrite & pready;
	assign rd = psel & penable & ~pwrite & ~pready;
	assign stop_rise = osc.stop_seen & ~stop_prev;
	assign force_slow = stop_rise | (NEWER & link_to_slow);

	always_comb
	begin
		flags = 8'h00;
		flags[cgs_pkg::FLG_MAIN_POS] = osc.main_stable;
		flags[cgs_pkg::FLG_PLL_POS] = pll_locked;
		flags[cgs_pkg::FLG_FAST_POS] = fast_osc_stable;
		flags[cgs_pkg::FLG_WDOG_POS] = NEWER & wdog_osc_stable;
	end

	always_comb
	begin
		mapped = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr)
			cgs_pkg::OFS_SCK:   rdata = sck;
			cgs_pkg::OFS_PLL:   rdata = {16'h0000, pllc};
			cgs_pkg::OFS_FLAGS: rdata = {24'h00_0000, flags};
			cgs_pkg::OFS_OSTD:  rdata = {24'h00_0000, ostd};
			cgs_pkg::OFS_MWAIT: rdata = {24'h00_0000, mwait};
			cgs_pkg::OFS_MDRV:  rdata = {24'h00_0000, mdrv};
			cgs_pkg::OFS_OSC:   rdata = oscc;
			cgs_pkg::OFS_SBY:
				rdata[cgs_pkg::SBY_SEL_POS] = sby_sel;
			cgs_pkg::OFS_MSTP:  rdata[MODULES-1:0] = mstop;
			cgs_pkg::OFS_STAT:
			begin
				rdata[cgs_pkg::STAT_STOP_POS] = stop_flag;
				rdata[cgs_pkg::STAT_LP_POS +: 2] = lp;
			end
			default:            mapped = 1'b0;
		endcase
	end

	// APB answer: one wait state, so pready rises in the second access cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (rd)
				prdata <= rdata;
		end
	end

	// Divider settings; older parts have no peripheral C divider.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sck <= cgs_pkg::SCK_RST;
		else if (wr && paddr == cgs_pkg::OFS_SCK)
		begin
			sck <= pwdata;
			if (!NEWER)
				sck[cgs_pkg::SCK_PCKC_POS +: 4] <= 4'h0;
		end
	end

	// A prohibited code leaves its field unchanged.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pllc <= cgs_pkg::PLL_RST;
		else if (wr && paddr == cgs_pkg::OFS_PLL)
		begin
			if (div_ok(pwdata[cgs_pkg::PLL_DIV_POS +: 2]))
				pllc[cgs_pkg::PLL_DIV_POS +: 2] <=
					pwdata[cgs_pkg::PLL_DIV_POS +: 2];
			if (mul_ok(pwdata[cgs_pkg::PLL_MUL_POS +: 6]))
				pllc[cgs_pkg::PLL_MUL_POS +: 6] <=
					pwdata[cgs_pkg::PLL_MUL_POS +: 6];
			pllc[cgs_pkg::PLL_SRC_POS] <=
				NEWER & pwdata[cgs_pkg::PLL_SRC_POS];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ostd <= cgs_pkg::OSTD_RST;
			mwait <= cgs_pkg::MWAIT_RST;
			mdrv <= cgs_pkg::MDRV_RST;
		end
		else if (wr)
		begin
			if (paddr == cgs_pkg::OFS_OSTD)
			begin
				ostd[cgs_pkg::OSTD_EN_POS] <= pwdata[cgs_pkg::OSTD_EN_POS];
				ostd[cgs_pkg::OSTD_IE_POS] <= pwdata[cgs_pkg::OSTD_IE_POS];
			end
			if (paddr == cgs_pkg::OFS_MWAIT && wait_ok(pwdata[7:0]))
				mwait <= pwdata[7:0];
			if (paddr == cgs_pkg::OFS_MDRV)
			begin
				mdrv[cgs_pkg::DRV_POS + 1] <= pwdata[cgs_pkg::DRV_POS + 1];
				mdrv[cgs_pkg::DRV_POS] <=
					NEWER & pwdata[cgs_pkg::DRV_POS];
			end
		end
	end

	// Forced fallback wins over a software write to the source in the same
	// cycle, so a stop is never lost behind a late reselection.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			oscc <= cgs_pkg::OSC_RST;
		else
		begin
			if (wr && paddr == cgs_pkg::OFS_OSC)
			begin
				oscc[2:0] <= pwdata[2:0];
				oscc[cgs_pkg::OSC_SRC_POS +: 3] <=
					pwdata[cgs_pkg::OSC_SRC_POS +: 3];
				if (NEWER && freq_ok(pwdata[cgs_pkg::OSC_FREQ_POS +: 2]))
					oscc[cgs_pkg::OSC_FREQ_POS +: 2] <=
						pwdata[cgs_pkg::OSC_FREQ_POS +: 2];
			end
			if (force_slow)
				oscc[cgs_pkg::OSC_SRC_POS +: 3] <= cgs_pkg::SRC_SLOW;
		end
	end

	// Stop status is sticky; write one to clear, a new stop wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stop_flag <= 1'b0;
			stop_prev <= 1'b0;
		end
		else
		begin
			stop_prev <= osc.stop_seen;
			stop_flag <= stop_rise | (stop_flag & ~(wr
				&& paddr == cgs_pkg::OFS_STAT
				&& pwdata[cgs_pkg::STAT_STOP_POS]));
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sby_sel <= 1'b0;
			mstop <= MODULES'(cgs_pkg::MSTP_RST);
		end
		else if (wr)
		begin
			if (paddr == cgs_pkg::OFS_SBY)
				sby_sel <= pwdata[cgs_pkg::SBY_SEL_POS];
			if (paddr == cgs_pkg::OFS_MSTP)
				mstop <= pwdata[MODULES-1:0];
		end
	end

	// Low power sequencing; the CPU resumes by taking the waking interrupt.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lp <= cgs_pkg::CGS_RUN;
			cpu_wake <= 1'b0;
		end
		else
		begin
			cpu_wake <= 1'b0;
			unique case (lp)
				cgs_pkg::CGS_RUN:
					if (wait_exec)
						lp <= sby_sel ? cgs_pkg::CGS_STANDBY
							: cgs_pkg::CGS_SLEEP;
				cgs_pkg::CGS_SLEEP, cgs_pkg::CGS_STANDBY:
					if (irq_pending)
					begin
						lp <= cgs_pkg::CGS_RUN;
						cpu_wake <= 1'b1;
					end
			endcase
		end
	end

	// Registered outputs.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			main_osc_en <= 1'b0;
			fast_osc_en <= 1'b0;
			slow_osc_en <= 1'b1;
			pll_en <= 1'b0;
			pll_from_fast <= 1'b0;
			pll_input_div <= 3'h1;
			pll_mult_halves <= 6'h14;
			main_osc_drive_range <= 2'h0;
			fast_osc_mhz <= NEWER ? cgs_pkg::FAST_16_MHZ
				: cgs_pkg::FAST_OLD_MHZ;
			clock_source <= cgs_pkg::SRC_SLOW;
			system_clock_div <= 4'h0;
			periph_clock_a_div <= 4'h0;
			periph_clock_b_div <= 4'h0;
			periph_clock_c_div <= 4'h0;
			periph_clock_d_div <= 4'h0;
			flash_if_clock_div <= 4'h0;
			cpu_clock_en <= 1'b1;
			memory_clock_en <= 1'b1;
			module_clock_en <= '0;
			wdt_hold <= 1'b0;
			motor_timer_hiz <= 1'b0;
			pwm_timer_hiz <= 1'b0;
			stop_detect_irq <= 1'b0;
			stop_event_out <= 1'b0;
		end
		else
		begin
			// Standby halts every general oscillator and the PLL.
			main_osc_en <= osc.main_en;
			fast_osc_en <= ~oscc[cgs_pkg::OSC_FAST_STOP_POS]
				& (lp != cgs_pkg::CGS_STANDBY);
			slow_osc_en <= lp != cgs_pkg::CGS_STANDBY;
			pll_en <= ~oscc[cgs_pkg::OSC_PLL_STOP_POS]
				& (lp != cgs_pkg::CGS_STANDBY);
			pll_from_fast <= pllc[cgs_pkg::PLL_SRC_POS];
			unique case (pllc[cgs_pkg::PLL_DIV_POS +: 2])
				2'h0:    pll_input_div <= 3'h1;
				2'h1:    pll_input_div <= 3'h2;
				default: pll_input_div <= NEWER ? 3'h3 : 3'h4;
			endcase
			pll_mult_halves <= pllc[cgs_pkg::PLL_MUL_POS +: 6]
				+ 6'h01;
			main_osc_drive_range <= mdrv[cgs_pkg::DRV_POS +: 2];
			if (NEWER)
				unique case (oscc[cgs_pkg::OSC_FREQ_POS +: 2])
					2'h1:    fast_osc_mhz <= cgs_pkg::FAST_18_MHZ;
					2'h2:    fast_osc_mhz <= cgs_pkg::FAST_20_MHZ;
					default: fast_osc_mhz <= cgs_pkg::FAST_16_MHZ;
				endcase
			else
				fast_osc_mhz <= cgs_pkg::FAST_OLD_MHZ;
			clock_source <= oscc[cgs_pkg::OSC_SRC_POS +: 3];
			system_clock_div <= sck[cgs_pkg::SCK_ICK_POS +: 4];
			periph_clock_a_div <= sck[cgs_pkg::SCK_PCKA_POS +: 4];
			periph_clock_b_div <= sck[cgs_pkg::SCK_PCKB_POS +: 4];
			periph_clock_c_div <= sck[cgs_pkg::SCK_PCKC_POS +: 4];
			periph_clock_d_div <= sck[cgs_pkg::SCK_PCKD_POS +: 4];
			flash_if_clock_div <= sck[cgs_pkg::SCK_FCK_POS +: 4];
			cpu_clock_en <= lp == cgs_pkg::CGS_RUN;
			memory_clock_en <= lp != cgs_pkg::CGS_STANDBY;
			module_clock_en <= ~mstop
				& {MODULES{lp != cgs_pkg::CGS_STANDBY}};
			wdt_hold <= NEWER & (lp != cgs_pkg::CGS_RUN);
			// Pin disable follows the enable, so clearing it frees the pins.
			motor_timer_hiz <= stop_flag & ostd[cgs_pkg::OSTD_IE_POS];
			pwm_timer_hiz <= NEWER & stop_flag
				& ostd[cgs_pkg::OSTD_IE_POS];
			stop_detect_irq <= stop_flag & ostd[cgs_pkg::OSTD_IE_POS];
			stop_event_out <= NEWER & stop_rise;
		end
	end
endmodule : cgs_clock_gen
`default_nettype wire

/* File: hw/cgs_pkg.sv */
// Constants and types shared by the clock generation and standby block.
package cgs_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_SCK   = 8'h00;
	localparam logic [7:0] OFS_PLL   = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_OSTD  = 8'h0c;
	localparam logic [7:0] OFS_MWAIT = 8'h10;
	localparam logic [7:0] OFS_MDRV  = 8'h14;
	localparam logic [7:0] OFS_OSC   = 8'h18;
	localparam logic [7:0] OFS_SBY   = 8'h1c;
	localparam logic [7:0] OFS_MSTP  = 8'h20;
	localparam logic [7:0] OFS_STAT  = 8'h24;
	// Reset values.
	localparam logic [31:0] SCK_RST   = 32'h0000_0000;
	localparam logic [15:0] PLL_RST   = 16'h1300;
	localparam logic [7:0]  OSTD_RST  = 8'h00;
	localparam logic [7:0]  MWAIT_RST = 8'h00;
	localparam logic [7:0]  MDRV_RST  = 8'h00;
	localparam logic [31:0] OSC_RST   = 32'h0000_0007;
	localparam logic [31:0] MSTP_RST  = 32'hffff_ffff;
	// Divider control field positions, four bits each.
	localparam int SCK_FCK_POS  = 28;
	localparam int SCK_ICK_POS  = 24;
	localparam int SCK_PCKA_POS = 12;
	localparam int SCK_PCKB_POS = 8;
	localparam int SCK_PCKD_POS = 4;
	localparam int SCK_PCKC_POS = 0;
	// PLL control field positions.
	localparam int PLL_DIV_POS = 0;
	localparam int PLL_SRC_POS = 4;
	localparam int PLL_MUL_POS = 8;
	// Stop detect control bits.
	localparam int OSTD_EN_POS = 0;
	localparam int OSTD_IE_POS = 7;
	// Drive range field; the older variant uses only its upper bit.
	localparam int DRV_POS = 4;
	// Oscillator control register bits.
	localparam int OSC_MAIN_STOP_POS = 0;
	localparam int OSC_FAST_STOP_POS = 1;
	localparam int OSC_PLL_STOP_POS  = 2;
	localparam int OSC_SRC_POS       = 8;
	localparam int OSC_FREQ_POS      = 16;
	// Stable flag bits.
	localparam int FLG_MAIN_POS = 0;
	localparam int FLG_PLL_POS  = 2;
	localparam int FLG_FAST_POS = 3;
	localparam int FLG_WDOG_POS = 4;
	// Standby control and status bits.
	localparam int SBY_SEL_POS   = 15;
	localparam int STAT_STOP_POS = 0;
	localparam int STAT_LP_POS   = 8;
	// System clock source codes.
	localparam logic [2:0] SRC_SLOW = 3'h0;
	localparam logic [2:0] SRC_FAST = 3'h1;
	localparam logic [2:0] SRC_MAIN = 3'h2;
	localparam logic [2:0] SRC_PLL  = 3'h4;
	// Slow oscillator ticks without a main tick that mean a stopped crystal.
	localparam logic [3:0] STOP_MISS_TICKS = 4'h8;
	// Fast oscillator frequencies in MHz.
	localparam logic [5:0] FAST_OLD_MHZ = 6'h20;
	localparam logic [5:0] FAST_16_MHZ  = 6'h10;
	localparam logic [5:0] FAST_18_MHZ  = 6'h12;
	localparam logic [5:0] FAST_20_MHZ  = 6'h14;

	typedef enum logic [1:0] {CGS_RUN, CGS_SLEEP, CGS_STANDBY} cgs_lp_t;
endpackage : cgs_pkg

/* File: hw/cgs_osc_if.sv */
// Signals between the register block and the main oscillator monitor.
`timescale 1ns/100ps
`default_nettype none
interface cgs_osc_if;
	logic       main_tick;
	logic       slow_tick;
	logic       main_en;
	logic       detect_en;
	logic [7:0] wait_code;
	logic       stop_seen;
	logic       main_stable;

	modport ctrl (output main_tick, slow_tick, main_en, detect_en,
		wait_code, input stop_seen, main_stable);
	modport mon (input main_tick, slow_tick, main_en, detect_en,
		wait_code, output stop_seen, main_stable);
endinterface : cgs_osc_if
`default_nettype wire

/* File: hw/cgs_osc_monitor.sv */
// Main oscillator start-up wait and stop detection, timed by the slow tick.
`timescale 1ns/100ps
`default_nettype none
module cgs_osc_monitor #(
	parameter bit NEWER = 1'b1
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Link to the register block
	cgs_osc_if.mon    osc
);
	logic [16:0] wait_cnt;
	logic [3:0]  miss_cnt;

	function automatic logic [16:0] wait_target(input logic [7:0] code);
		if (NEWER)
			wait_target = {4'h0, code, 5'h00};
		else if (code[4:0] == 5'h00)
			wait_target = 17'h0_0002;
		else
			wait_target = 17'h0_0200 << code[2:0];
	endfunction : wait_target

	// Start-up wait counts slow oscillator cycles after enable.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_cnt <= 17'h0_0000;
			osc.main_stable <= 1'b0;
		end
		else if (!osc.main_en)
		begin
			wait_cnt <= 17'h0_0000;
			osc.main_stable <= 1'b0;
		end
		else if (osc.slow_tick && !osc.main_stable)
		begin
			wait_cnt <= wait_cnt + 17'h0_0001;
			osc.main_stable <= (wait_cnt + 17'h0_0001)
				>= wait_target(osc.wait_code);
		end
	end

	// A stop is judged only after the oscillator was once declared stable.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			miss_cnt <= 4'h0;
			osc.stop_seen <= 1'b0;
		end
		else if (!osc.detect_en || !osc.main_stable || osc.main_tick)
		begin
			miss_cnt <= 4'h0;
			osc.stop_seen <= 1'b0;
		end
		else if (osc.slow_tick && miss_cnt != cgs_pkg::STOP_MISS_TICKS)
			miss_cnt <= miss_cnt + 4'h1;
		else if (miss_cnt == cgs_pkg::STOP_MISS_TICKS)
			osc.stop_seen <= 1'b1;
	end
endmodule : cgs_osc_monitor
`default_nettype wire

/* File: verification/cgs_props.sv */
// Port-level assertions for the clock generation block.
`timescale 1ns/100ps
`default_nettype none
module cgs_props #(
	parameter bit NEWER   = 1'b1,
	parameter int MODULES = 32
) (
	// Clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// CPU side
	input wire logic               wait_exec,
	input wire logic               irq_pending,
	// Oscillator controls
	input wire logic               main_osc_en,
	input wire logic               fast_osc_en,
	input wire logic               pll_en,
	input wire logic [2:0]         pll_input_div,
	input wire logic [5:0]         pll_mult_halves,
	input wire logic [5:0]         fast_osc_mhz,
	input wire logic [2:0]         clock_source,
	// Gating and low power
	input wire logic               cpu_clock_en,
	input wire logic               memory_clock_en,
	input wire logic [MODULES-1:0] module_clock_en,
	input wire logic               wdt_hold,
	input wire logic               cpu_wake,
	// Stop detection
	input wire logic               motor_timer_hiz,
	input wire logic               pwm_timer_hiz,
	input wire logic               stop_detect_irq,
	input wire logic               stop_event_out
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_hiz_slow: assert property (
		$rose(motor_timer_hiz) |-> clock_source == cgs_pkg::SRC_SLOW)
		else $error("timer pins floated without slow source");
	a_irq_gate: assert property (
		stop_detect_irq == motor_timer_hiz &&
		pwm_timer_hiz == (NEWER && motor_timer_hiz))
		else $error("stop report and interrupt disagree");
	a_div_codes: assert property (
		NEWER ? pll_input_div inside {3'h1, 3'h2, 3'h3} :
		pll_input_div inside {3'h1, 3'h2, 3'h4})
		else $error("pll input ratio outside legal set");
	a_mult_range: assert property (
		pll_mult_halves >= (NEWER ? 6'h14 : 6'h08) &&
		pll_mult_halves <= (NEWER ? 6'h3c : 6'h14))
		else $error("pll multiplier outside legal range");
	a_fast_freq: assert property (
		NEWER ? fast_osc_mhz inside {6'h10, 6'h12, 6'h14} :
		fast_osc_mhz == 6'h20)
		else $error("fast oscillator frequency illegal");
	a_event_pulse: assert property (
		stop_event_out |-> NEWER ##1 !stop_event_out)
		else $error("stop event not a single pulse");
	a_sleep_entry: assert property (
		wait_exec && cpu_clock_en && !irq_pending |=> ##1 !cpu_clock_en)
		else $error("wait did not stop the cpu clock");
	a_wake_pulse: assert property (
		cpu_wake |=> cpu_clock_en && !cpu_wake)
		else $error("wake did not restart the cpu clock");
	a_standby_off: assert property (
		!memory_clock_en |-> !cpu_clock_en && !main_osc_en &&
		!fast_osc_en && !pll_en && module_clock_en == '0)
		else $error("standby left a clock running");
	a_sleep_hold: assert property (
		!cpu_clock_en && memory_clock_en |-> wdt_hold == NEWER)
		else $error("watchdog hold wrong in sleep");
endmodule : cgs_props
`default_nettype wire

/* File: verification/cgs_osc_model.sv */
// Resonator model that ticks the main and slow oscillator inputs.
`timescale 1ns/100ps
`default_nettype none
module cgs_osc_model (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Enable from the block, failure switch from the bench
	input  wire logic main_osc_en,
	input  wire logic run_main,
	// Oscillator ticks
	output logic      main_osc_tick,
	output logic      slow_osc_tick
);
	logic [1:0] phase;

	// The crystal swings only while enabled and not failed on purpose.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase <= 2'h0;
			main_osc_tick <= 1'b0;
			slow_osc_tick <= 1'b0;
		end
		else
		begin
			phase <= phase + 2'h1;
			slow_osc_tick <= (phase == 2'h3);
			main_osc_tick <= main_osc_en && run_main && !main_osc_tick;
		end
	end
endmodule : cgs_osc_model
`default_nettype wire

/* File: verification/cgs_clock_gen_tb.sv */
// Self-checking bench for the clock generation block.
`timescale 1ns/100ps
`default_nettype none
module cgs_clock_gen_tb;
	localparam int MODULES = 32;
	logic               pclk = 1'b0;
	logic               presetn, psel, penable, pwrite, pready;
	logic               pslverr, err, run_main, wait_exec, irq_pending;
	logic               main_osc_tick, slow_osc_tick, link_to_slow;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic               main_osc_en, fast_osc_en, slow_osc_en, pll_en;
	logic               pll_from_fast, cpu_clock_en, memory_clock_en;
	logic               wdt_hold, cpu_wake, motor_timer_hiz, pwm_timer_hiz;
	logic               stop_detect_irq, stop_event_out;
	logic [2:0]         pll_input_div, clock_source;
	logic [5:0]         pll_mult_halves, fast_osc_mhz;
	logic [1:0]         main_osc_drive_range;
	logic [3:0]         system_clock_div, periph_clock_a_div, n_ev;
	logic [3:0]         periph_clock_b_div, periph_clock_c_div, n_wake;
	logic [3:0]         periph_clock_d_div, flash_if_clock_div;
	logic [MODULES-1:0] module_clock_en;
	int                 miscompares, num_checks;

	cgs_clock_gen #(.NEWER(1'b1), .MODULES(MODULES)) dut_u (
		.fast_osc_stable(1'b1), .pll_locked(1'b0),
		.wdog_osc_stable(run_main), .*);
	cgs_osc_model osc_u (.*);

	always #50 pclk = ~pclk;
	always @(posedge pclk)
	begin
		n_ev <= n_ev + 4'(stop_event_out);
		n_wake <= n_wake + 4'(cpu_wake);
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic t_reset;
		chk({pll_input_div, pll_mult_halves, fast_osc_mhz, slow_osc_en},
			{3'h1, 6'h14, 6'h10, 1'b1});
		apb(1'b0, cgs_pkg::OFS_PLL, 32'h0);
		chk(rd, 32'h1300);
		apb(1'b0, cgs_pkg::OFS_OSC, 32'h0);
		chk(rd, 32'h7);
		apb(1'b0, cgs_pkg::OFS_MSTP, 32'h0);
		chk(rd, 32'hffff_ffff);
		apb(1'b0, cgs_pkg::OFS_FLAGS, 32'h0);
		chk(rd[4], 1'b1);
		apb(1'b1, 8'h40, 32'h5);
		apb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b1);
		$display("test reset done");
	endtask : t_reset

	task automatic t_fields;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, cgs_pkg::OFS_PLL, 32'h1300 | i);
			cyc(2);
			chk(pll_input_div, (i == 3) ? 3 : i + 1);
			apb(1'b1, cgs_pkg::OFS_OSC, 32'h7 | (i << 16));
			cyc(2);
			chk(fast_osc_mhz, (i == 0) ? 16 : (i == 1) ? 18 : 20);
		end
		apb(1'b1, cgs_pkg::OFS_PLL, 32'h3b12);
		cyc(2);
		chk({pll_from_fast, pll_mult_halves}, {1'b1, 6'h3c});
		apb(1'b1, cgs_pkg::OFS_PLL, 32'h3c12);
		apb(1'b0, cgs_pkg::OFS_PLL, 32'h0);
		chk(rd, 32'h3b12);
		apb(1'b1, cgs_pkg::OFS_SCK, 32'h9800_4321);
		apb(1'b1, cgs_pkg::OFS_MDRV, 32'h20);
		apb(1'b1, cgs_pkg::OFS_MSTP, 32'hffff_0000);
		cyc(2);
		chk({flash_if_clock_div, system_clock_div, periph_clock_a_div,
			periph_clock_b_div, periph_clock_d_div, periph_clock_c_div,
			main_osc_drive_range}, {24'h984321, 2'b10});
		chk(module_clock_en, 32'h0000_ffff);
		$display("test fields done");
	endtask : t_fields

	task automatic t_stop;
		apb(1'b1, cgs_pkg::OFS_MWAIT, 32'h1);
		apb(1'b1, cgs_pkg::OFS_OSTD, 32'h81);
		apb(1'b1, cgs_pkg::OFS_OSC, 32'h206);
		repeat (80)
		begin
			apb(1'b0, cgs_pkg::OFS_FLAGS, 32'h0);
			if (rd[0] === 1'b1) break;
		end
		chk({rd[0], main_osc_en, clock_source}, {2'b11, cgs_pkg::SRC_MAIN});
		run_main <= 1'b0;
		repeat (100)
		begin
			@(posedge pclk);
			if (motor_timer_hiz === 1'b1) break;
		end
		cyc(1);
		chk({clock_source, pwm_timer_hiz, stop_detect_irq, n_ev},
			{cgs_pkg::SRC_SLOW, 2'b11, 4'h1});
		apb(1'b0, cgs_pkg::OFS_FLAGS, 32'h0);
		chk(rd[4:0], 5'h09);
		run_main <= 1'b1;
		apb(1'b1, cgs_pkg::OFS_OSTD, 32'h01);
		cyc(2);
		chk({motor_timer_hiz, stop_detect_irq}, 2'b00);
		apb(1'b1, cgs_pkg::OFS_STAT, 32'h1);
		apb(1'b0, cgs_pkg::OFS_STAT, 32'h0);
		chk(rd[0], 1'b0);
		apb(1'b1, cgs_pkg::OFS_OSC, 32'h200);
		cyc(2);
		chk(clock_source, cgs_pkg::SRC_MAIN);
		link_to_slow <= 1'b1;
		cyc(1);
		link_to_slow <= 1'b0;
		cyc(2);
		chk(clock_source, cgs_pkg::SRC_SLOW);
		$display("test stop done");
	endtask : t_stop

	task automatic t_lp(input logic sel);
		apb(1'b1, cgs_pkg::OFS_SBY, {16'h0, sel, 15'h0});
		wait_exec <= 1'b1;
		cyc(1);
		wait_exec <= 1'b0;
		cyc(3);
		apb(1'b0, cgs_pkg::OFS_STAT, 32'h0);
		chk(rd[9:8], sel ? 2 : 1);
		chk({cpu_clock_en, memory_clock_en, wdt_hold, main_osc_en,
			fast_osc_en, pll_en, slow_osc_en},
			{1'b0, !sel, 1'b1, {4{!sel}}});
		irq_pending <= 1'b1;
		cyc(1);
		irq_pending <= 1'b0;
		cyc(3);
		chk({cpu_clock_en, n_wake}, {1'b1, sel ? 4'h2 : 4'h1});
		$display("test low power done");
	endtask : t_lp

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	initial
	begin
		{presetn, psel, penable, pwrite, wait_exec} = '0;
		{irq_pending, link_to_slow, paddr, pwdata, n_ev, n_wake} = '0;
		run_main = 1'b1;
		cyc(6);
		presetn <= 1'b1;
		cyc(1);
		t_reset();
		t_fields();
		t_stop();
		t_lp(1'b0);
		t_lp(1'b1);
		end_sim();
	end

	initial
	begin
		#1_000_000;
		miscompares++;
		end_sim();
	end
endmodule : cgs_clock_gen_tb

bind cgs_clock_gen cgs_props #(.NEWER(NEWER), .MODULES(MODULES)) props_u (
	.*);
`default_nettype wire
